// ==== rtl/flash_pkg.sv ====
package flash_pkg;

	// ****************************************************************
	// array and register geometry
	// ****************************************************************
	localparam int          ADDR_W      = 24;
	localparam int          BPR_W       = 48;
	localparam int          NVL_W       = 40;
	localparam int          MEM_BYTES   = 64;
	localparam int          SID_BYTES   = 16;
	localparam int          FIFO_W      = 8;
	localparam int          FIFO_D      = 4;
	// write locks set, read locks clear after power-on
	localparam logic [47:0] BPR_RESET   = 48'h5555_FFFF_FFFF;
	localparam logic [47:0] RLOCK_MASK  = 48'hAAAA_0000_0000;
	localparam logic [39:0] NVL_RESET   = 40'h00_0000_0000;
	localparam logic [10:0] SID_FACT_N  = 11'h008;
	// factory identifier, value arbitrary
	localparam logic [63:0] SID_FACTORY = 64'h0123_4567_89AB_CDEF;
	localparam logic [7:0]  ERASED      = 8'hFF;

	// ****************************************************************
	// command codes
	// ****************************************************************
	localparam logic [7:0] CMD_WRITE_ENABLE_CMD  = 8'h06;
	localparam logic [7:0] CMD_WRDI  = 8'h04;
	localparam logic [7:0] CMD_EQIO  = 8'h38;
	localparam logic [7:0] CMD_RSTQ  = 8'hFF;
	localparam logic [7:0] CMD_RDSR  = 8'h05;
	localparam logic [7:0] CMD_RDCR  = 8'h35;
	localparam logic [7:0] CMD_WRSR  = 8'h01;
	localparam logic [7:0] CMD_READ  = 8'h03;
	localparam logic [7:0] CMD_DREAD = 8'h3B;
	localparam logic [7:0] CMD_QREAD = 8'h6B;
	localparam logic [7:0] CMD_PP    = 8'h02;
	localparam logic [7:0] CMD_SE    = 8'h20;
	localparam logic [7:0] CMD_RBPR  = 8'h72;
	localparam logic [7:0] CMD_PROTECTION_WRITE_CMD  = 8'h42;
	localparam logic [7:0] CMD_PROTECTION_FREEZE_CMD  = 8'h8D;
	localparam logic [7:0] CMD_ULBPR = 8'h98;
	localparam logic [7:0] CMD_WNVL  = 8'hE8;
	localparam logic [7:0] CMD_RSID  = 8'h88;
	localparam logic [7:0] CMD_SECURE_ID_PROGRAM_CMD  = 8'hA5;
	localparam logic [7:0] CMD_SECURE_ID_LOCKOUT_CMD  = 8'h85;

	// ****************************************************************
	// register fields and byte counts
	// ****************************************************************
	localparam int         SR_BUSY  = 0;
	localparam int         SR_WEL   = 1;
	localparam int         SR_FRZ   = 4;
	localparam int         SR_SEC   = 5;
	localparam int         SR_BUSY7 = 7;
	localparam int         CF_IOC   = 1;
	localparam int         CF_BPNV  = 3;
	localparam int         CF_PROTECT_PIN_ENABLE  = 7;
	localparam logic [2:0] N_ADDR   = 3'h3;
	localparam logic [2:0] N_BPR    = 3'h6;
	localparam logic [2:0] N_NVL    = 3'h5;
	localparam logic [2:0] N_CFG    = 3'h2;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int         CLK_MHZ    = 200;
	localparam int         OP_TIME_NS = 200;
	localparam logic [7:0] OP_CYC     =
		8'((OP_TIME_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [4:0] {
		ST_CMD   = 5'b00001,
		ST_ADDR  = 5'b00010,
		ST_WDATA = 5'b00100,
		ST_RDATA = 5'b01000,
		ST_SKIP  = 5'b10000
	} phase_t;

	typedef enum logic [3:0] {
		OP_NONE  = 4'b0001,
		OP_PROG  = 4'b0010,
		OP_ERASE = 4'b0100,
		OP_SID   = 4'b1000
	} op_t;

endpackage : flash_pkg

// ==== rtl/serial_flash_protect_hold.sv ====
`timescale 1ns/100ps

// ********************************************************************
// small data buffer
// ********************************************************************
module fifo_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             clear,
	input  wire logic             in_valid,
	output      logic             in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output      logic             out_valid,
	input  wire logic             out_ready,
	output      logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_q [DEPTH];
	logic [PW:0]      wp_q;
	logic [PW:0]      rp_q;
	logic             push;
	logic             pop;

	assign in_ready  = !((wp_q[PW] != rp_q[PW]) &&
		(wp_q[PW-1:0] == rp_q[PW-1:0]));
	assign out_valid = (wp_q != rp_q);
	assign out_data  = store_q[rp_q[PW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (reset || clear) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push)
				wp_q <= wp_q + 1'b1;
			if (pop)
				rp_q <= rp_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			store_q[wp_q[PW-1:0]] <= in_data;
	end
endmodule : fifo_buf

// ********************************************************************
// device-side command interface
// ********************************************************************
module serial_flash_protect_hold (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       factory_reset,
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic [3:0] io_in,
	input  wire logic       wp_n,
	input  wire logic       hold_n,
	output      logic [3:0] io_out,
	output      logic [3:0] io_oe
);
	import flash_pkg::*;

	function automatic logic is_param(input logic [23:0] a);
		is_param = (a[20:16] == 5'h00 && !a[15]) ||
			(a[20:16] == 5'h1F && a[15]);
	endfunction : is_param

	// 8K blocks at both ends, 32K beside them, 64K elsewhere
	function automatic logic [5:0] wl_index(input logic [23:0] a);
		wl_index = is_param(a) ? {2'b10, a[20], a[14:13], 1'b0}
			: {1'b0, a[20:16]};
	endfunction : wl_index

	function automatic logic [47:0] nv_to_bpr(input logic [39:0] n);
		nv_to_bpr = {16'h0000, n[31:0]};
		for (int i = 0; i < 8; i++)
			nv_to_bpr[32 + 2 * i] = n[32 + i];
	endfunction : nv_to_bpr

	function automatic phase_t next_phase(input logic [7:0] c,
		input logic busy);
		if (busy)
			next_phase = (c == CMD_RDSR) ? ST_RDATA : ST_SKIP;
		else begin
			unique case (c)
				CMD_RDSR, CMD_RDCR, CMD_RBPR:
					next_phase = ST_RDATA;
				CMD_READ, CMD_DREAD, CMD_QREAD, CMD_RSID,
				CMD_PP, CMD_SE, CMD_SECURE_ID_PROGRAM_CMD:
					next_phase = ST_ADDR;
				CMD_PROTECTION_WRITE_CMD, CMD_WNVL, CMD_WRSR:
					next_phase = ST_WDATA;
				default:
					next_phase = ST_SKIP;
			endcase
		end
	endfunction : next_phase

	// ****************************************************************
	// pin synchronisers and edge detection
	// ****************************************************************
	logic [7:0] s1_q;
	logic [7:0] s2_q;
	logic       sck_p_q;
	logic       cs_p_q;
	logic [3:0] io_s;
	logic       cs_s;
	logic       sck_s;
	logic       hold_s;
	logic       wp_s;
	logic       sel;
	logic       cs_rise;
	logic       hold_q;
	logic       rise_act;
	logic       fall_act;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			s1_q    <= 8'hF0;
			s2_q    <= 8'hF0;
			sck_p_q <= 1'b0;
			cs_p_q  <= 1'b1;
		end else begin
			s1_q    <= {wp_n, hold_n, sck, cs_n, io_in};
			s2_q    <= s1_q;
			sck_p_q <= s2_q[5];
			cs_p_q  <= s2_q[4];
		end
	end

	assign io_s     = s2_q[3:0];
	assign cs_s     = s2_q[4];
	assign sck_s    = s2_q[5];
	assign hold_s   = s2_q[6];
	assign wp_s     = s2_q[7];
	assign sel      = !cs_s;
	assign cs_rise  = cs_s && !cs_p_q;
	// edges only count in a frame; idle level is irrelevant
	assign rise_act = sel && !hold_q && sck_s && !sck_p_q;
	assign fall_act = sel && !hold_q && !sck_s && sck_p_q;

	// ****************************************************************
	// hold pause
	// ****************************************************************
	logic quad_q;
	logic ioc_q;

	// level only takes effect while the clock is low
	always_ff @(posedge core_clk) begin
		if (reset || !sel || quad_q || ioc_q)
			hold_q <= 1'b0;
		else if (!sck_s)
			hold_q <= !hold_s;
	end

	// ****************************************************************
	// byte receive
	// ****************************************************************
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic [7:0] rx_byte;
	logic       byte_done;

	assign rx_byte   = quad_q ? {sh_q[3:0], io_s}
		: {sh_q[6:0], io_s[0]};
	assign byte_done = rise_act && (quad_q ? bit_q == 3'h4
		: bit_q == 3'h7);

	always_ff @(posedge core_clk) begin
		if (reset || !sel) begin
			sh_q  <= 8'h00;
			bit_q <= 3'h0;
		end else if (rise_act) begin
			sh_q  <= rx_byte;
			bit_q <= bit_q + (quad_q ? 3'h4 : 3'h1);
		end
	end

	// ****************************************************************
	// command sequencer
	// ****************************************************************
	phase_t      phase_q;
	logic [7:0]  cmd_q;
	logic [2:0]  cnt_q;
	logic [23:0] addr_q;
	logic [39:0] wbuf_q;
	op_t         pend_q;
	logic        busy_q;
	logic        load_byte;
	logic        cmd_now;
	logic        wlast;
	logic [2:0]  need;
	logic [47:0] wfull;
	logic        f_in_ready;

	assign cmd_now = byte_done && phase_q == ST_CMD && !busy_q;
	assign need    = (cmd_q == CMD_PROTECTION_WRITE_CMD) ? N_BPR :
		(cmd_q == CMD_WNVL) ? N_NVL : (cmd_q == CMD_WRSR) ? N_CFG : 3'h0;
	assign wlast   = byte_done && phase_q == ST_WDATA &&
		need != 3'h0 && cnt_q == need - 3'h1;
	assign wfull   = {wbuf_q, rx_byte};

	always_ff @(posedge core_clk) begin
		if (reset || !sel) begin
			phase_q <= ST_CMD;
			cnt_q   <= 3'h0;
			pend_q  <= OP_NONE;
			cmd_q   <= 8'h00;
			wbuf_q  <= 40'h00_0000_0000;
		end else begin
			if (byte_done) begin
				unique case (phase_q)
					ST_CMD: begin
						cmd_q   <= rx_byte;
						cnt_q   <= 3'h0;
						phase_q <= next_phase(rx_byte, busy_q);
					end
					ST_ADDR: begin
						addr_q <= {addr_q[15:0], rx_byte};
						cnt_q  <= cnt_q + 3'h1;
						if (cnt_q == N_ADDR - 3'h1) begin
							if (cmd_q == CMD_PP) begin
								pend_q  <= OP_PROG;
								phase_q <= ST_WDATA;
							end else if (cmd_q == CMD_SECURE_ID_PROGRAM_CMD) begin
								pend_q  <= OP_SID;
								phase_q <= ST_WDATA;
							end else if (cmd_q == CMD_SE) begin
								pend_q  <= OP_ERASE;
								phase_q <= ST_SKIP;
							end else
								phase_q <= ST_RDATA;
						end
					end
					ST_WDATA: begin
						wbuf_q <= wfull[39:0];
						if (need == 3'h0 || f_in_ready)
							cnt_q <= cnt_q + 3'h1;
						if (wlast)
							phase_q <= ST_SKIP;
					end
					ST_RDATA, ST_SKIP: begin
					end
					default:
						phase_q <= ST_CMD;
				endcase
			end
			if (load_byte) begin
				addr_q <= addr_q + 24'h00_0001;
				cnt_q  <= cnt_q + 3'h1;
			end
		end
	end

	// ****************************************************************
	// protection state
	// ****************************************************************
	logic [47:0] bpr_q;
	logic [39:0] nvl_q;
	logic        wel_q;
	logic        freeze_q;
	logic        protect_pin_enable_q;
	logic        sec_q;
	logic        wp_block;
	logic        bpr_ok;
	logic        op_done;
	logic [47:0] nv_map;
	logic        ev_protection_write_cmd;
	logic        ev_wcfg;
	logic        ev_wnv;
	logic        ev_unlock;
	logic        ev_freeze;
	logic        ev_secure_id_lockout_cmd;

	assign ev_protection_write_cmd   = wlast && cmd_q == CMD_PROTECTION_WRITE_CMD;
	assign ev_wcfg   = wlast && cmd_q == CMD_WRSR;
	assign ev_wnv    = wlast && cmd_q == CMD_WNVL;
	assign ev_unlock = cmd_now && rx_byte == CMD_ULBPR;
	assign ev_freeze = cmd_now && rx_byte == CMD_PROTECTION_FREEZE_CMD;
	assign ev_secure_id_lockout_cmd   = cmd_now && rx_byte == CMD_SECURE_ID_LOCKOUT_CMD;
	assign nv_map    = nv_to_bpr(nvl_q);
	// pin ignored in quad mode or with io config set
	assign wp_block  = !quad_q && !ioc_q && protect_pin_enable_q && !wp_s;
	assign bpr_ok    = wel_q && !freeze_q && !wp_block;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			bpr_q <= BPR_RESET;
		end else if (ev_protection_write_cmd && bpr_ok) begin
			bpr_q <= wfull | nv_map;
		end else if (ev_unlock && bpr_ok) begin
			bpr_q <= (bpr_q & RLOCK_MASK) | nv_map;
		end else begin
			bpr_q <= bpr_q | nv_map;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			wel_q <= 1'b0;
		else if (cmd_now && rx_byte == CMD_WRITE_ENABLE_CMD)
			wel_q <= 1'b1;
		else if ((cmd_now && rx_byte == CMD_WRDI) || ev_protection_write_cmd ||
			ev_unlock || ev_freeze || ev_wcfg || ev_wnv || ev_secure_id_lockout_cmd ||
			op_done)
			wel_q <= 1'b0;
	end

	// only a power cycle clears it
	always_ff @(posedge core_clk) begin
		if (reset)
			freeze_q <= 1'b0;
		else if (ev_freeze && wel_q)
			freeze_q <= 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ioc_q  <= 1'b0;
			quad_q <= 1'b0;
		end else begin
			if (ev_wcfg && wel_q && !wp_block)
				ioc_q <= rx_byte[CF_IOC];
			if (cmd_now && rx_byte == CMD_EQIO)
				quad_q <= 1'b1;
			else if (cmd_now && rx_byte == CMD_RSTQ)
				quad_q <= 1'b0;
		end
	end

	// ****************************************************************
	// program and erase engine
	// ****************************************************************
	op_t         op_q;
	logic [7:0]  bcnt_q;
	logic [23:0] waddr_q;
	logic        ok_q;
	logic        start_op;
	logic        f_in_valid;
	logic        f_out_valid;
	logic [7:0]  f_out_data;
	logic        pop;

	assign start_op   = cs_rise && pend_q != OP_NONE && wel_q &&
		!busy_q;
	assign f_in_valid = byte_done && phase_q == ST_WDATA && need == 3'h0;
	// drain stalls while the frame runs, so the buffer fills
	assign pop        = f_out_valid && busy_q;
	assign op_done    = busy_q && bcnt_q == 8'h00 && !f_out_valid;

	fifo_buf #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_D)
	) u_buf (
		.clk       (core_clk),
		.reset     (reset),
		.clear     (cs_rise && !start_op && !busy_q),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (rx_byte),
		.out_valid (f_out_valid),
		.out_ready (busy_q),
		.out_data  (f_out_data)
	);

	// write-protect pin deliberately not consulted here
	always_ff @(posedge core_clk) begin
		if (reset) begin
			busy_q  <= 1'b0;
			bcnt_q  <= 8'h00;
			op_q    <= OP_NONE;
			waddr_q <= 24'h00_0000;
			ok_q    <= 1'b0;
		end else if (start_op) begin
			busy_q  <= 1'b1;
			bcnt_q  <= OP_CYC;
			op_q    <= pend_q;
			waddr_q <= addr_q;
			ok_q    <= !bpr_q[wl_index(addr_q)];
		end else if (busy_q) begin
			if (pop)
				waddr_q <= waddr_q + 24'h00_0001;
			if (bcnt_q != 8'h00)
				bcnt_q <= bcnt_q - 8'h01;
			else if (!f_out_valid)
				busy_q <= 1'b0;
		end
	end

	// ****************************************************************
	// nonvolatile contents, untouched by reset, restored to factory values by factory reset
	// ****************************************************************
	logic [7:0] mem_q [MEM_BYTES];
	logic [7:0] sid_q [SID_BYTES];

	always_ff @(posedge core_clk) begin
		if (factory_reset) begin
			for (int i = 0; i < MEM_BYTES; i++)
				mem_q[i] <= ERASED;
			for (int i = 0; i < SID_BYTES; i++)
				sid_q[i] <= (i < 8) ? SID_FACTORY[8 * (7 - i) +: 8]
					: ERASED;
			nvl_q  <= NVL_RESET;
			protect_pin_enable_q <= 1'b0;
			sec_q  <= 1'b0;
		end else begin
			if (start_op && pend_q == OP_ERASE &&
				!bpr_q[wl_index(addr_q)])
				for (int i = 0; i < MEM_BYTES; i++)
					mem_q[i] <= ERASED;
			if (pop && op_q == OP_PROG && ok_q)
				mem_q[waddr_q[5:0]] <= mem_q[waddr_q[5:0]] & f_out_data;
			if (pop && op_q == OP_SID && !sec_q &&
				waddr_q[10:0] >= SID_FACT_N)
				sid_q[waddr_q[3:0]] <= f_out_data;
			if (ev_wnv && wel_q && !freeze_q)
				nvl_q <= nvl_q | wfull[39:0];
			if (ev_wcfg && wel_q && !wp_block)
				protect_pin_enable_q <= rx_byte[CF_PROTECT_PIN_ENABLE];
			if (ev_secure_id_lockout_cmd && wel_q)
				sec_q <= 1'b1;
		end
	end

	// ****************************************************************
	// read data and output shifter
	// ****************************************************************
	logic [7:0]  rd_byte;
	logic [7:0]  cur_byte;
	logic [7:0]  out_sh_q;
	logic [2:0]  ocnt_q;
	logic [2:0]  out_w;
	logic [3:0]  oe_mask;
	logic [47:0] bpr_sh;
	logic        drove_q;
	logic        rd_lock;

	assign bpr_sh   = bpr_q << {cnt_q, 3'h0};
	assign rd_lock  = is_param(addr_q) &&
		bpr_q[wl_index(addr_q) | 6'h01];
	assign out_w    = (quad_q || cmd_q == CMD_QREAD) ? 3'h4 :
		(cmd_q == CMD_DREAD) ? 3'h2 : 3'h1;
	assign oe_mask  = (out_w == 3'h4) ? 4'hF :
		(out_w == 3'h2) ? 4'h3 : 4'h2;
	assign cur_byte = (ocnt_q == 3'h0) ? rd_byte : out_sh_q;
	assign load_byte = fall_act && phase_q == ST_RDATA &&
		ocnt_q == 3'h0;

	always_comb begin
		rd_byte = 8'h00;
		unique case (cmd_q)
			CMD_RDSR: begin
				rd_byte[SR_BUSY]  = busy_q;
				rd_byte[SR_BUSY7] = busy_q;
				rd_byte[SR_WEL]   = wel_q;
				rd_byte[SR_FRZ]   = freeze_q;
				rd_byte[SR_SEC]   = sec_q;
			end
			CMD_RDCR: begin
				rd_byte[CF_IOC]  = ioc_q;
				rd_byte[CF_BPNV] = (nvl_q == NVL_RESET);
				rd_byte[CF_PROTECT_PIN_ENABLE] = protect_pin_enable_q;
			end
			CMD_RBPR:
				rd_byte = bpr_sh[47:40];
			CMD_READ, CMD_DREAD, CMD_QREAD:
				rd_byte = rd_lock ? 8'h00 : mem_q[addr_q[5:0]];
			CMD_RSID:
				rd_byte = sid_q[addr_q[3:0]];
			default:
				rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset || !sel) begin
			io_out   <= 4'h0;
			io_oe    <= 4'h0;
			out_sh_q <= 8'h00;
			ocnt_q   <= 3'h0;
			drove_q  <= 1'b0;
		end else begin
			if (fall_act && phase_q == ST_RDATA) begin
				unique case (out_w)
					3'h4: io_out <= cur_byte[7:4];
					3'h2: io_out <= {2'b00, cur_byte[7:6]};
					default: io_out <= {2'b00, cur_byte[7], 1'b0};
				endcase
				out_sh_q <= cur_byte << out_w;
				ocnt_q   <= ocnt_q - out_w;
				drove_q  <= 1'b1;
			end
			// output floats for the whole pause
			io_oe <= (hold_q || !(drove_q ||
				(fall_act && phase_q == ST_RDATA))) ? 4'h0
				: oe_mask;
		end
	end
endmodule : serial_flash_protect_hold

// ==== bench/flash_prot_chk.sv ====
`timescale 1ns/100ps
module flash_prot_chk (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic       hold_n,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	// ****************************************************************
	// output lanes
	// ****************************************************************
	oe_reset_a: assert property ($fell(reset) |-> (io_oe == 4'h0)[*2])
		else $error("lines driven right after reset");
	out_reset_a: assert property ($fell(reset) |-> io_out == 4'h0)
		else $error("output data not cleared by reset");
	lane_set_a: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
		else $error("illegal set of driven lines");
	deselect_float_a: assert property (cs_n [*5] |-> io_oe == 4'h0)
		else $error("lines driven while deselected");
	oe_drop_a: assert property ($fell(|io_oe) |-> cs_n || !hold_n)
		else $error("drive dropped inside a frame");
	// edge checks assume high and low phases of at least four clocks
	oe_start_a: assert property ($rose(|io_oe) |->
		!$past(cs_n, 4) && !$past(sck, 2))
		else $error("drive started off a falling edge");
	out_fall_a: assert property ($changed(io_out) && !cs_n |->
		!$past(sck, 2) && $past(sck, 6))
		else $error("output changed away from a falling edge");
	out_steady_a: assert property ((sck && !cs_n) [*4] |->
		$stable(io_out))
		else $error("output moved while clock high");
endmodule : flash_prot_chk

bind serial_flash_protect_hold flash_prot_chk chk (
	.core_clk(core_clk),
	.reset   (reset),
	.cs_n    (cs_n),
	.sck     (sck),
	.hold_n  (hold_n),
	.io_out  (io_out),
	.io_oe   (io_oe)
);

// ==== bench/flash_host.sv ====
`timescale 1ns/100ps
module flash_host (
	input  wire logic       core_clk,
	input  wire logic [3:0] io_out,
	output      logic       cs_n,
	output      logic       sck,
	output      logic [3:0] host_io
);
	// 80 ns serial clock: eight core clocks per phase
	localparam int HALF = 8;

	initial begin
		cs_n    = 1'b1;
		sck     = 1'b0;
		host_io = 4'h0;
	end

	task automatic start();
		@(posedge core_clk);
		cs_n <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask : start

	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			host_io[0] <= tx[i];
			repeat (HALF) @(posedge core_clk);
			rx[i] = io_out[1];
			sck <= 1'b1;
			repeat (HALF) @(posedge core_clk);
			sck <= 1'b0;
		end
	endtask : xfer

	task automatic stop();
		repeat (HALF) @(posedge core_clk);
		cs_n    <= 1'b1;
		// released lines never keep the last value
		host_io <= ~host_io;
		repeat (HALF) @(posedge core_clk);
	endtask : stop
endmodule : flash_host

// ==== bench/test_serial_flash_protect_hold.sv ====
`timescale 1ns/100ps
module test_serial_flash_protect_hold;
	import flash_pkg::*;

	logic        core_clk = 1'b0;
	logic        reset    = 1'b1;
	logic        fac_rst  = 1'b1;
	logic        wp_n     = 1'b1;
	logic        hold_n   = 1'b1;
	logic        cs_n;
	logic        sck;
	logic [3:0]  host_io;
	logic [3:0]  io_in;
	logic [3:0]  io_out;
	logic [3:0]  io_oe;
	logic [47:0] q;
	int          n_mismatch = 0;
	int          n_compared = 0;

	always #2.5 core_clk = ~core_clk;
	assign io_in = (io_oe & io_out) | (~io_oe & host_io);

	flash_host host (
		.core_clk(core_clk),
		.io_out  (io_out),
		.cs_n    (cs_n),
		.sck     (sck),
		.host_io (host_io)
	);

	serial_flash_protect_hold dut (
		.core_clk     (core_clk),
		.reset        (reset),
		.factory_reset(fac_rst),
		.cs_n         (cs_n),
		.sck          (sck),
		.io_in        (io_in),
		.wp_n         (wp_n),
		.hold_n       (hold_n),
		.io_out       (io_out),
		.io_oe        (io_oe)
	);

	// ****************************************************************
	// frame tasks
	// ****************************************************************
	task automatic frame(input logic [7:0] op, input logic [47:0] d,
		input int n);
		logic [7:0] r;
		host.start();
		host.xfer(op, r);
		q = '0;
		for (int i = n - 1; i >= 0; i--) begin
			host.xfer(d[8*i +: 8], r);
			q = {q[39:0], r};
		end
		host.stop();
	endtask : frame

	task automatic cmd(input logic [7:0] op);
		frame(op, '0, 0);
	endtask : cmd

	task automatic pwr(input logic fac);
		@(posedge core_clk);
		reset   <= 1'b1;
		fac_rst <= fac;
		repeat (8) @(posedge core_clk);
		reset   <= 1'b0;
		fac_rst <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask : pwr

	// status polling bounded: a stuck busy shows up in later compares
	task automatic wait_idle();
		for (int k = 0; k < 20; k++) begin
			frame(CMD_RDSR, '0, 1);
			if (q[0] === 1'b0)
				break;
		end
	endtask : wait_idle

	task automatic chk8(input logic [7:0] exp);
		n_compared++;
		if (q[7:0] !== exp) begin
			n_mismatch++;
			$display("BAD %0t byte %h want %h", $time, q[7:0], exp);
		end
	endtask : chk8

	task automatic chk48(input logic [47:0] exp);
		frame(CMD_RBPR, '0, 6);
		n_compared++;
		if (q !== exp) begin
			n_mismatch++;
			$display("BAD %0t prot %h want %h", $time, q, exp);
		end
	endtask : chk48

	task automatic end_of_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test

	// ****************************************************************
	// sequence
	// ****************************************************************
	initial begin
		pwr(1'b1);
		frame(CMD_RDSR, '0, 1);
		chk8(8'h00);
		chk48(48'h5555_FFFF_FFFF);
		frame(CMD_PROTECTION_WRITE_CMD, '0, 6);
		chk48(48'h5555_FFFF_FFFF);
		// paused frame: clock edges must be ignored, so no latch set
		hold_n <= 1'b0;
		cmd(CMD_WRITE_ENABLE_CMD);
		hold_n <= 1'b1;
		frame(CMD_RDSR, '0, 1);
		chk8(8'h00);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_RDSR, '0, 1);
		chk8(8'h02);
		cmd(CMD_ULBPR);
		chk48(48'h0000_0000_0000);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_PP, 48'h0000_0000_00A5, 4);
		wait_idle();
		chk8(8'h00);
		frame(CMD_READ, '0, 4);
		chk8(8'hA5);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_PROTECTION_WRITE_CMD, 48'h0002_0000_0000, 6);
		frame(CMD_READ, '0, 4);
		chk8(8'h00);
		frame(CMD_RDSR, '0, 1);
		chk8(8'h00);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_WNVL, 48'h0001_0000_0000, 5);
		chk48(48'h0003_0000_0000);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_PROTECTION_WRITE_CMD, '0, 6);
		chk48(48'h0001_0000_0000);
		cmd(CMD_WRITE_ENABLE_CMD);
		cmd(CMD_PROTECTION_FREEZE_CMD);
		frame(CMD_RDSR, '0, 1);
		chk8(8'h10);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_PROTECTION_WRITE_CMD, 48'hFFFF_FFFF_FFFF, 6);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_WNVL, 48'h0000_0000_0001, 5);
		chk48(48'h0001_0000_0000);
		pwr(1'b0);
		frame(CMD_RDSR, '0, 1);
		chk8(8'h00);
		cmd(CMD_WRITE_ENABLE_CMD);
		cmd(CMD_ULBPR);
		chk48(48'h0001_0000_0000);
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_WRSR, 48'h0000_0000_0080, 2);
		frame(CMD_RDCR, '0, 1);
		chk8(8'h80);
		wp_n <= 1'b0;
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_PROTECTION_WRITE_CMD, 48'hFFFF_FFFF_FFFF, 6);
		chk48(48'h0001_0000_0000);
		wp_n <= 1'b1;
		cmd(CMD_WRITE_ENABLE_CMD);
		frame(CMD_PROTECTION_WRITE_CMD, 48'h0000_0000_0001, 6);
		chk48(48'h0001_0000_0001);
		end_of_test();
	end

	initial begin
		repeat (90000) @(posedge core_clk);
		n_mismatch++;
		end_of_test();
	end
endmodule : test_serial_flash_protect_hold
